// ---- rlsq_pkg.sv ----
// constants for the receiver and lo sequencer serial control block
package rlsq_pkg;
  localparam int unsigned REG_COUNT = 128;
  localparam int unsigned ADDR_W = 15;
  localparam int unsigned HDR_BITS = 16;
  localparam logic [6:0] SERIAL_PORT_CONFIG = 7'h00;
  localparam logic [6:0] RECEIVER_WRAP_MODE = 7'h1a;
  localparam logic [6:0] RECEIVER_SEQ_ENABLE = 7'h1b;
  localparam logic [6:0] RECEIVER_DIRECT_ENABLES = 7'h1c;
  localparam logic [6:0] RECEIVER_DIRECT_GAIN_A = 7'h1d;
  localparam logic [6:0] RECEIVER_DIRECT_GAIN_B = 7'h1e;
  localparam logic [6:0] MULTIPLIER_WRAP_MODE = 7'h22;
  localparam logic [6:0] MULTIPLIER_SEQ_ENABLE = 7'h23;
  localparam logic [6:0] MULTIPLIER_DIRECT = 7'h24;
  localparam logic [6:0] RECEIVER_FIRST_MODE_ENABLES = 7'h40;
  localparam logic [6:0] RECEIVER_FIRST_MODE_GAIN_A = 7'h41;
  localparam logic [6:0] RECEIVER_FIRST_MODE_GAIN_B = 7'h42;
  localparam logic [6:0] MULTIPLIER_FIRST_MODE = 7'h70;
  localparam logic [6:0] RX_MODE_STRIDE = 7'h03;
  // field positions and reset values
  localparam int unsigned FOUR_WIRE_HI = 4;
  localparam int unsigned FOUR_WIRE_LO = 3;
  localparam int unsigned WRAP_TARGET_HI = 7;
  localparam int unsigned WRAP_TARGET_LO = 4;
  localparam int unsigned LAST_MODE_HI = 3;
  localparam int unsigned LAST_MODE_LO = 0;
  localparam int unsigned SEQ_ENABLE_BIT = 0;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [3:0] MODE_ZERO = 4'h0;
endpackage

// ---- rlsq_top.sv ----
// serial register port and two mode sequencers of a four-channel receiver
`timescale 1ns/1ns

// What this block does
// - serial port acts only while select is low; ignores clock and data otherwise
// - shifted-in write bytes reach the registers when select returns high
// - register 0 bits 4 and 3 both set: read data on dedicated output
// - those bits clear, the reset default: read data on shared data line
// - host serial clock times both write sampling and read shifting
// - enabled receiver restart returns channels to mode-zero settings at once
// - enabled receiver step moves to next mode and applies it
// - receiver step at last mode wraps to mode in 0x1a bits 7:4
// - enabled multiplier restart restores mode-zero configuration at 0x70
// - enabled multiplier step moves to next mode
// - multiplier step at last mode wraps to mode in 0x22 bits 7:4
// - address increments after every data byte until select rises
// - all sequenced functions also settable directly by register writes
module rlsq_top (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic select_n,
  input wire logic serial_clk,
  input wire logic sdio_in,
  output logic sdio_out,
  output logic sdio_oe,
  output logic sdo,
  input wire logic receiver_sequence_restart_pin,
  input wire logic receiver_sequence_step_pin,
  input wire logic lo_sequence_restart_pin,
  input wire logic lo_sequence_step_pin,
  output logic [7:0] rx_channel_enables,
  output logic [7:0] rx_gain_a,
  output logic [7:0] rx_gain_b,
  output logic [7:0] lo_mult_config
);

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers: all pins come from the host's domain
  logic [5:0] pin_meta_q;
  logic [5:0] pin_sync_q;
  logic [5:0] pin_prev_q;
  wire [5:0] pin_raw = {lo_sequence_step_pin, lo_sequence_restart_pin,
    receiver_sequence_step_pin, receiver_sequence_restart_pin,
    serial_clk, select_n};

  always_ff @(posedge sys_clk) begin
    // reset to idle levels (select high, clock and pulses low): no false edge
    if (rst) begin
      pin_meta_q <= 6'h01;
      pin_sync_q <= 6'h01;
      pin_prev_q <= 6'h01;
    end else begin
      pin_meta_q <= pin_raw;
      pin_sync_q <= pin_meta_q;
      pin_prev_q <= pin_sync_q;
    end
  end

  // data line needs only two stages; it is sampled on a clock edge
  logic sdi_meta_q;
  logic sdi_sync_q;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sdi_meta_q <= 1'b0;
      sdi_sync_q <= 1'b0;
    end else begin
      sdi_meta_q <= sdio_in;
      sdi_sync_q <= sdi_meta_q;
    end
  end

  wire sel_active = ~pin_sync_q[0];
  wire sel_rise = pin_sync_q[0] & ~pin_prev_q[0];
  wire sclk_rise = pin_sync_q[1] & ~pin_prev_q[1];
  wire sclk_fall = ~pin_sync_q[1] & pin_prev_q[1];
  wire [3:0] pulse_rise = pin_sync_q[5:2] & ~pin_prev_q[5:2];

  ////////////////////////////////////////////////////////////////////////
  // register storage: live copy steers logic, shadow holds pending writes
  logic [7:0] live_q [rlsq_pkg::REG_COUNT];
  logic [7:0] shadow_q [rlsq_pkg::REG_COUNT];
  logic [rlsq_pkg::REG_COUNT-1:0] dirty_q;

  ////////////////////////////////////////////////////////////////////////
  // serial engine
  typedef enum logic [1:0] {RLSQ_IDLE, RLSQ_HDR, RLSQ_DATA} rlsq_state_t;
  rlsq_state_t state_q;
  logic [4:0] bit_cnt_q;
  logic [15:0] in_sr_q;
  logic read_q;
  logic [rlsq_pkg::ADDR_W-1:0] addr_q;
  logic [7:0] out_sr_q;
  logic out_bit_q;

  wire [15:0] in_next = {in_sr_q[14:0], sdi_sync_q};
  wire hdr_done = (state_q == RLSQ_HDR) && sclk_rise &&
    (bit_cnt_q == 5'(rlsq_pkg::HDR_BITS - 1));
  // a byte closing as select rises is dropped, not left half committed
  wire byte_done = sel_active && (state_q == RLSQ_DATA) && sclk_rise &&
    (bit_cnt_q == 5'd7);
  wire [rlsq_pkg::ADDR_W-1:0] hdr_addr = in_next[14:0];
  wire [rlsq_pkg::ADDR_W-1:0] addr_inc =
    rlsq_pkg::ADDR_W'(addr_q + 15'h0001);
  wire [rlsq_pkg::ADDR_W-1:0] load_addr = hdr_done ? hdr_addr : addr_inc;
  wire load_mapped = (load_addr[14:7] == 8'h00);
  wire [7:0] load_byte = load_mapped ? live_q[load_addr[6:0]] : 8'h00;
  wire addr_mapped = (addr_q[14:7] == 8'h00);

  always_ff @(posedge sys_clk) begin
    if (rst || !sel_active) begin
      state_q <= RLSQ_IDLE;
      bit_cnt_q <= 5'h00;
      in_sr_q <= 16'h0000;
      read_q <= 1'b0;
      addr_q <= 15'h0000;
    end else begin
      case (state_q)
        RLSQ_IDLE: begin
          state_q <= RLSQ_HDR;
          bit_cnt_q <= 5'h00;
        end
        RLSQ_HDR: begin
          if (sclk_rise) begin
            in_sr_q <= in_next;
            bit_cnt_q <= hdr_done ? 5'h00 : 5'(bit_cnt_q + 5'h01);
            if (hdr_done) begin
              read_q <= in_next[15];
              addr_q <= hdr_addr;
              state_q <= RLSQ_DATA;
            end
          end
        end
        RLSQ_DATA: begin
          if (sclk_rise) begin
            in_sr_q <= in_next;
            bit_cnt_q <= byte_done ? 5'h00 : 5'(bit_cnt_q + 5'h01);
            if (byte_done) begin
              addr_q <= addr_inc;
            end
          end
        end
        default: state_q <= RLSQ_IDLE;
      endcase
    end
  end

  // read shifter: loaded on the closing rising edge, shifted on falling
  always_ff @(posedge sys_clk) begin
    if (rst || !sel_active) begin
      out_sr_q <= 8'h00;
      out_bit_q <= 1'b0;
    end else if ((hdr_done && in_next[15]) || (byte_done && read_q)) begin
      out_sr_q <= load_byte;
    end else if (sclk_fall && state_q == RLSQ_DATA && read_q) begin
      out_bit_q <= out_sr_q[7];
      out_sr_q <= {out_sr_q[6:0], 1'b0};
    end
  end

  // pending writes are staged so nothing changes until select rises
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dirty_q <= '0;
    end else if (sel_rise) begin
      dirty_q <= '0;
    end else if (byte_done && !read_q && addr_mapped) begin
      shadow_q[addr_q[6:0]] <= in_next[7:0];
      dirty_q[addr_q[6:0]] <= 1'b1;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < rlsq_pkg::REG_COUNT; gi++) begin : g_reg
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          live_q[gi] <= rlsq_pkg::REG_RESET;
        end else if (sel_rise && dirty_q[gi]) begin
          live_q[gi] <= shadow_q[gi];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // read-back pin selection
  wire [7:0] port_cfg = live_q[rlsq_pkg::SERIAL_PORT_CONFIG];
  wire four_wire = &port_cfg[rlsq_pkg::FOUR_WIRE_HI:rlsq_pkg::FOUR_WIRE_LO];
  wire read_phase = sel_active && (state_q == RLSQ_DATA) && read_q;

  assign sdo = four_wire & read_phase & out_bit_q;
  assign sdio_oe = ~four_wire & read_phase;
  assign sdio_out = sdio_oe & out_bit_q;

  ////////////////////////////////////////////////////////////////////////
  // sequencers
  wire [7:0] rx_wrap = live_q[rlsq_pkg::RECEIVER_WRAP_MODE];
  wire [7:0] lo_wrap = live_q[rlsq_pkg::MULTIPLIER_WRAP_MODE];
  wire rx_seq_en =
    live_q[rlsq_pkg::RECEIVER_SEQ_ENABLE][rlsq_pkg::SEQ_ENABLE_BIT];
  wire lo_seq_en =
    live_q[rlsq_pkg::MULTIPLIER_SEQ_ENABLE][rlsq_pkg::SEQ_ENABLE_BIT];
  wire [3:0] rx_last = rx_wrap[rlsq_pkg::LAST_MODE_HI:rlsq_pkg::LAST_MODE_LO];
  wire [3:0] lo_last = lo_wrap[rlsq_pkg::LAST_MODE_HI:rlsq_pkg::LAST_MODE_LO];
  wire [3:0] rx_target =
    rx_wrap[rlsq_pkg::WRAP_TARGET_HI:rlsq_pkg::WRAP_TARGET_LO];
  wire [3:0] lo_target =
    lo_wrap[rlsq_pkg::WRAP_TARGET_HI:rlsq_pkg::WRAP_TARGET_LO];

  logic [3:0] rx_ptr_q;
  logic [3:0] lo_ptr_q;

  // restart has priority over a coincident step
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rx_ptr_q <= rlsq_pkg::MODE_ZERO;
    end else if (rx_seq_en) begin
      if (pulse_rise[0]) begin
        rx_ptr_q <= rlsq_pkg::MODE_ZERO;
      end else if (pulse_rise[1]) begin
        rx_ptr_q <= (rx_ptr_q == rx_last) ? rx_target :
          4'(rx_ptr_q + 4'h1);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      lo_ptr_q <= rlsq_pkg::MODE_ZERO;
    end else if (lo_seq_en) begin
      if (pulse_rise[2]) begin
        lo_ptr_q <= rlsq_pkg::MODE_ZERO;
      end else if (pulse_rise[3]) begin
        lo_ptr_q <= (lo_ptr_q == lo_last) ? lo_target :
          4'(lo_ptr_q + 4'h1);
      end
    end
  end

  // mode n of the receiver sits three registers above mode n-1
  wire [6:0] rx_base = 7'(rlsq_pkg::RECEIVER_FIRST_MODE_ENABLES +
    7'(rx_ptr_q) * rlsq_pkg::RX_MODE_STRIDE);
  wire [6:0] rx_ga_idx = 7'(rx_base + rlsq_pkg::RECEIVER_FIRST_MODE_GAIN_A
    - rlsq_pkg::RECEIVER_FIRST_MODE_ENABLES);
  wire [6:0] rx_gb_idx = 7'(rx_base + rlsq_pkg::RECEIVER_FIRST_MODE_GAIN_B
    - rlsq_pkg::RECEIVER_FIRST_MODE_ENABLES);
  wire [6:0] lo_idx = 7'(rlsq_pkg::MULTIPLIER_FIRST_MODE + 7'(lo_ptr_q));

  // registered outputs; direct registers rule while a sequencer is off
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rx_channel_enables <= rlsq_pkg::REG_RESET;
      rx_gain_a <= rlsq_pkg::REG_RESET;
      rx_gain_b <= rlsq_pkg::REG_RESET;
      lo_mult_config <= rlsq_pkg::REG_RESET;
    end else begin
      rx_channel_enables <= rx_seq_en ? live_q[rx_base] :
        live_q[rlsq_pkg::RECEIVER_DIRECT_ENABLES];
      rx_gain_a <= rx_seq_en ? live_q[rx_ga_idx] :
        live_q[rlsq_pkg::RECEIVER_DIRECT_GAIN_A];
      rx_gain_b <= rx_seq_en ? live_q[rx_gb_idx] :
        live_q[rlsq_pkg::RECEIVER_DIRECT_GAIN_B];
      lo_mult_config <= lo_seq_en ? live_q[lo_idx] :
        live_q[rlsq_pkg::MULTIPLIER_DIRECT];
    end
  end

endmodule // rlsq_top

// ---- rlsq_top_properties.sv ----
// port assertions for the receiver and lo sequencer serial block
`timescale 1ns/1ns
module rlsq_top_properties (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic select_n,
  input wire logic serial_clk,
  input wire logic sdio_in,
  input wire logic sdio_out,
  input wire logic sdio_oe,
  input wire logic sdo,
  input wire logic receiver_sequence_restart_pin,
  input wire logic receiver_sequence_step_pin,
  input wire logic lo_sequence_restart_pin,
  input wire logic lo_sequence_step_pin,
  input wire logic [7:0] rx_channel_enables,
  input wire logic [7:0] rx_gain_a,
  input wire logic [7:0] rx_gain_b,
  input wire logic [7:0] lo_mult_config
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_oe_needs_select: assert property (select_n [*3] |-> !sdio_oe)
    else $error("shared line driven while deselected");
  a_sdo_needs_select: assert property (select_n [*4] |-> !sdo)
    else $error("dedicated output active while deselected");
  a_one_read_pin: assert property (sdio_oe |-> !sdo)
    else $error("both read pins active");
  a_released_low: assert property (!sdio_oe |-> !sdio_out)
    else $error("shared data nonzero while released");
  a_read_bit_steady: assert property (serial_clk [*3] |->
    $stable(sdo) && $stable(sdio_out))
    else $error("read bit moved while serial clock high");
  a_rx_hold_steady: assert property ((select_n &&
    !receiver_sequence_restart_pin && !receiver_sequence_step_pin) [*8]
    |=> $stable({rx_channel_enables, rx_gain_a, rx_gain_b}))
    else $error("receiver settings moved without cause");
  a_lo_hold_steady: assert property ((select_n &&
    !lo_sequence_restart_pin && !lo_sequence_step_pin) [*8]
    |=> $stable(lo_mult_config))
    else $error("multiplier setting moved without cause");
  a_reset_clear: assert property ($fell(rst) |-> !sdo && !sdio_oe &&
    {rx_channel_enables, rx_gain_a, rx_gain_b, lo_mult_config} == 32'h0)
    else $error("outputs not clear after reset");
endmodule // rlsq_top_properties
bind rlsq_top rlsq_top_properties u_rlsq_top_properties (.sys_clk(sys_clk),
  .rst(rst), .select_n(select_n), .serial_clk(serial_clk),
  .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe), .sdo(sdo),
  .receiver_sequence_restart_pin(receiver_sequence_restart_pin),
  .receiver_sequence_step_pin(receiver_sequence_step_pin),
  .lo_sequence_restart_pin(lo_sequence_restart_pin),
  .lo_sequence_step_pin(lo_sequence_step_pin),
  .rx_channel_enables(rx_channel_enables), .rx_gain_a(rx_gain_a),
  .rx_gain_b(rx_gain_b), .lo_mult_config(lo_mult_config));

// ---- rlsq_host_model.sv ----
// host controller model: serial frames and sequencer pulses
`timescale 1ns/1ns
module rlsq_host_model (
  input wire logic sys_clk,
  output logic select_n,
  output logic serial_clk,
  output logic sdio_in,
  input wire logic sdio_out,
  input wire logic sdio_oe,
  input wire logic sdo,
  output logic receiver_sequence_restart_pin,
  output logic receiver_sequence_step_pin,
  output logic lo_sequence_restart_pin,
  output logic lo_sequence_step_pin
);
  logic h_d = 1'b0;
  logic h_oe = 1'b1;
  logic [3:0] pins_q;
  initial begin
    select_n = 1'b1;
    serial_clk = 1'b0;
    pins_q = 4'h0;
  end
  assign receiver_sequence_restart_pin = pins_q[0];
  assign receiver_sequence_step_pin = pins_q[1];
  assign lo_sequence_restart_pin = pins_q[2];
  assign lo_sequence_step_pin = pins_q[3];
  // no pull on the data line: released shows inverse of the last bit
  assign sdio_in = sdio_oe ? sdio_out : (h_oe ? h_d : ~h_d);
  ////////////////////////////////////////////////////////////////////////
  task automatic frame(input logic cs, input logic rd, input logic [14:0] a,
    input logic [31:0] wd, input int n, output logic [31:0] r3,
    output logic [31:0] r4);
    logic [47:0] s;
    s = {rd, a, wd << (32 - 8 * n)};
    r3 = 32'h0;
    r4 = 32'h0;
    @(posedge sys_clk) select_n <= ~cs;
    repeat (4) @(posedge sys_clk);
    for (int i = 0; i < 16 + 8 * n; i++) begin
      h_oe <= !(rd && i >= 16);
      h_d <= s[47 - i];
      serial_clk <= 1'b0;
      repeat (4) @(posedge sys_clk);
      serial_clk <= 1'b1;
      if (i >= 16) begin
        r3 = {r3[30:0], sdio_in};
        r4 = {r4[30:0], sdo};
      end
      repeat (4) @(posedge sys_clk);
    end
    serial_clk <= 1'b0;
    h_oe <= 1'b1;
    repeat (2) @(posedge sys_clk);
    select_n <= 1'b1;
    repeat (8) @(posedge sys_clk);
  endtask
  // pulse held well past the three-cycle minimum on both levels
  task automatic pulse(input int k);
    @(posedge sys_clk) pins_q[k] <= 1'b1;
    repeat (4) @(posedge sys_clk);
    pins_q[k] <= 1'b0;
    repeat (8) @(posedge sys_clk);
  endtask
endmodule // rlsq_host_model

// ---- rlsq_top_tb.sv ----
// self-checking bench for the receiver and lo sequencer serial block
`timescale 1ns/1ns
module rlsq_top_tb;
  logic sys_clk = 1'b0;
  logic rst;
  logic select_n, serial_clk, sdio_in, sdio_out, sdio_oe, sdo;
  logic receiver_sequence_restart_pin, receiver_sequence_step_pin;
  logic lo_sequence_restart_pin, lo_sequence_step_pin;
  logic [7:0] rx_en, rx_ga, rx_gb, lo_cfg;
  logic [31:0] r3, r4;
  int fails = 0;
  int checked = 0;
  always #20 sys_clk = ~sys_clk;
  rlsq_top u_rlsq_top (.sys_clk(sys_clk), .rst(rst), .select_n(select_n),
    .serial_clk(serial_clk), .sdio_in(sdio_in), .sdio_out(sdio_out),
    .sdio_oe(sdio_oe), .sdo(sdo),
    .receiver_sequence_restart_pin(receiver_sequence_restart_pin),
    .receiver_sequence_step_pin(receiver_sequence_step_pin),
    .lo_sequence_restart_pin(lo_sequence_restart_pin),
    .lo_sequence_step_pin(lo_sequence_step_pin), .rx_channel_enables(rx_en),
    .rx_gain_a(rx_ga), .rx_gain_b(rx_gb), .lo_mult_config(lo_cfg));
  rlsq_host_model u_rlsq_host_model (.sys_clk(sys_clk), .select_n(select_n),
    .serial_clk(serial_clk), .sdio_in(sdio_in), .sdio_out(sdio_out),
    .sdio_oe(sdio_oe), .sdo(sdo),
    .receiver_sequence_restart_pin(receiver_sequence_restart_pin),
    .receiver_sequence_step_pin(receiver_sequence_step_pin),
    .lo_sequence_restart_pin(lo_sequence_restart_pin),
    .lo_sequence_step_pin(lo_sequence_step_pin));
  ////////////////////////////////////////////////////////////////////////
  task automatic cmp(input string w, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [31:0] d, input int n);
    u_rlsq_host_model.frame(1'b1, 1'b0, {8'h00, a}, d, n, r3, r4);
  endtask
  task automatic rd(input logic [6:0] a, input int n);
    u_rlsq_host_model.frame(1'b1, 1'b1, {8'h00, a}, 32'h0, n, r3, r4);
  endtask
  task automatic finish_test();
    if (fails == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_direct();
    cmp("outputs", 32'h0, {rx_en, rx_ga, rx_gb, lo_cfg});
    rd(rlsq_pkg::SERIAL_PORT_CONFIG, 1);
    cmp("config", 32'h0, r3);
    wr(rlsq_pkg::RECEIVER_DIRECT_ENABLES, 32'ha53c, 2);
    cmp("direct", 32'ha53c, {rx_en, rx_ga});
    u_rlsq_host_model.frame(1'b0, 1'b0, 15'h1e, 32'hff, 1, r3, r4);
    cmp("deselected", 32'h0, rx_gb);
    rd(rlsq_pkg::RECEIVER_DIRECT_ENABLES, 2);
    cmp("block read", 32'ha53c, r3);
    cmp("sdo idle", 32'h0, r4);
    wr(rlsq_pkg::SERIAL_PORT_CONFIG, 32'h18, 1);
    rd(rlsq_pkg::RECEIVER_DIRECT_GAIN_A, 1);
    cmp("sdo read", 32'h3c, r4);
    cmp("shared released", 32'hff, r3);
    wr(rlsq_pkg::SERIAL_PORT_CONFIG, 32'h0, 1);
  endtask
  task automatic t_rx();
    wr(rlsq_pkg::RECEIVER_FIRST_MODE_ENABLES, 32'h112233, 3);
    wr(7'h43, 32'h445566, 3);
    // last mode 1, wrap to 0, sequencer enabled
    wr(rlsq_pkg::RECEIVER_WRAP_MODE, 32'h0101, 2);
    u_rlsq_host_model.pulse(1);
    cmp("rx step", 32'h445566, {rx_en, rx_ga, rx_gb});
    u_rlsq_host_model.pulse(1);
    cmp("rx wrap", 32'h112233, {rx_en, rx_ga, rx_gb});
    u_rlsq_host_model.pulse(1);
    u_rlsq_host_model.pulse(0);
    cmp("rx restart", 32'h112233, {rx_en, rx_ga, rx_gb});
    wr(rlsq_pkg::RECEIVER_SEQ_ENABLE, 32'h0, 1);
    cmp("rx direct", 32'ha53c00, {rx_en, rx_ga, rx_gb});
    u_rlsq_host_model.pulse(1);
    wr(rlsq_pkg::RECEIVER_SEQ_ENABLE, 32'h1, 1);
    cmp("rx ignored", 32'h112233, {rx_en, rx_ga, rx_gb});
  endtask
  task automatic t_lo();
    wr(rlsq_pkg::MULTIPLIER_FIRST_MODE, 32'hfa7a, 2);
    // last mode 1, wrap to 0, sequencer still off
    wr(rlsq_pkg::MULTIPLIER_WRAP_MODE, 32'h01, 1);
    wr(rlsq_pkg::MULTIPLIER_DIRECT, 32'h6e, 1);
    cmp("lo direct", 32'h6e, lo_cfg);
    u_rlsq_host_model.pulse(3);
    wr(rlsq_pkg::MULTIPLIER_SEQ_ENABLE, 32'h1, 1);
    cmp("lo ignored", 32'hfa, lo_cfg);
    u_rlsq_host_model.pulse(3);
    cmp("lo step", 32'h7a, lo_cfg);
    u_rlsq_host_model.pulse(3);
    cmp("lo wrap", 32'hfa, lo_cfg);
    u_rlsq_host_model.pulse(3);
    u_rlsq_host_model.pulse(2);
    cmp("lo restart", 32'hfa, lo_cfg);
  endtask
  // mid-run reset must drop four-wire mode and clear everything
  task automatic t_reset();
    wr(rlsq_pkg::SERIAL_PORT_CONFIG, 32'h18, 1);
    @(posedge sys_clk) rst <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    cmp("after reset", 32'h0, {rx_en, rx_ga, rx_gb, lo_cfg});
    rd(rlsq_pkg::MULTIPLIER_FIRST_MODE, 1);
    cmp("cleared reg", 32'h0, r3);
  endtask
  initial begin
    rst = 1'b1;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    t_direct();
    t_rx();
    t_lo();
    t_reset();
    finish_test();
  end
  // roughly ten times the expected run
  initial begin
    #2000000;
    fails++;
    finish_test();
  end
endmodule // rlsq_top_tb
